// *** core/fdsm_pkg.sv ***
// constants for the fast detect and signal monitor control block
package fdsm_pkg;
  // register indices; byte address is four times the index
  localparam int             IDX_W          = 12;
  localparam int             ADDR_LSB       = 2;
  localparam logic [11:0]    IDX_UP_LO      = 12'h247;
  localparam logic [11:0]    IDX_UP_HI      = 12'h248;
  localparam logic [11:0]    IDX_LO_LO      = 12'h249;
  localparam logic [11:0]    IDX_LO_HI      = 12'h24a;
  localparam logic [11:0]    IDX_DW_LO      = 12'h24b;
  localparam logic [11:0]    IDX_DW_HI      = 12'h24c;
  localparam logic [11:0]    IDX_SYNC_CTL   = 12'h26f;
  localparam logic [11:0]    IDX_MON_CTL    = 12'h270;
  localparam logic [11:0]    IDX_IRQ_STAT   = 12'h280;
  localparam logic [11:0]    IDX_IRQ_MASK   = 12'h281;

  // field layout
  localparam int             BYTE_W         = 8;
  localparam int             SYNC_EN_BIT    = 0;
  localparam int             SYNC_NEXT_BIT  = 1;
  localparam int             SYNC_W         = 2;
  localparam int             PEAK_EN_BIT    = 1;

  // interrupt status bits
  localparam int             IRQ_W          = 3;
  localparam int             IRQ_ALARM_ON   = 0;
  localparam int             IRQ_ALARM_OFF  = 1;
  localparam int             IRQ_SYNC       = 2;

  // reset values
  localparam logic [7:0]     RST_BYTE       = 8'h00;
  localparam logic [1:0]     RST_SYNC       = 2'h0;
  localparam logic [2:0]     RST_IRQ        = 3'h0;
  localparam logic [31:0]    RST_WORD       = 32'h0000_0000;

  // ahb-lite codes
  localparam int             HTRANS_ACT_BIT = 1;
  localparam logic           HRESP_OKAY     = 1'b0;
endpackage

// *** core/fdsm_ctrl.sv ***
// fast detect thresholds, dwell, signal monitor sync and peak enable over ahb-lite
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module fdsm_ctrl #(
  parameter int MAG_W   = 13,
  parameter int DWELL_W = 16
) (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic [MAG_W-1:0]  fine_magnitude,
  input  wire logic              sysref_pin,
  output logic                   threshold_alarm_output,
  output logic                   monitor_sync_pulse,
  output logic                   peak_detect_enable,
  output logic                   irq
);
  localparam int HI_W = MAG_W - fdsm_pkg::BYTE_W;

  if (MAG_W <= fdsm_pkg::BYTE_W || MAG_W > 2 * fdsm_pkg::BYTE_W) begin : g_bad_mag
    $error("fdsm_ctrl: MAG_W must lie in 9..16");
  end
  if (DWELL_W != 2 * fdsm_pkg::BYTE_W) begin : g_bad_dwell
    $error("fdsm_ctrl: DWELL_W must be two bytes");
  end

  function automatic logic [fdsm_pkg::IDX_W-1:0] word_index(input logic [31:0] a);
    word_index = a[fdsm_pkg::ADDR_LSB +: fdsm_pkg::IDX_W];
  endfunction

  // register storage
  logic [7:0]               up_lo_reg;
  logic [HI_W-1:0]          up_hi_reg;
  logic [7:0]               lo_lo_reg;
  logic [HI_W-1:0]          lo_hi_reg;
  logic [7:0]               dw_lo_reg;
  logic [7:0]               dw_hi_reg;
  logic [1:0]               sync_ctl_reg;
  logic [fdsm_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [fdsm_pkg::IRQ_W-1:0] irq_mask_reg;

  // bus state
  logic                     wr_pend_reg;
  logic                     rd_pend_reg;
  logic [fdsm_pkg::IDX_W-1:0] idx_reg;
  logic                     take;

  // datapath state
  logic [DWELL_W-1:0]       dwell_cnt_reg;
  logic                     sysref_meta_reg;
  logic                     sysref_sync_reg;
  logic                     sysref_prev_reg;

  logic [MAG_W-1:0]         up_thr;
  logic [MAG_W-1:0]         lo_thr;
  logic [DWELL_W-1:0]       dwell_val;
  logic                     above_up;
  logic                     below_lo;
  logic                     sysref_edge;
  logic                     valid_edge;
  logic                     alarm_next;
  logic [fdsm_pkg::IRQ_W-1:0] irq_set;
  logic                     wr_sync;
  logic [31:0]              rd_word;

  assign take = hsel && hready && htrans[fdsm_pkg::HTRANS_ACT_BIT];
  assign wr_sync = wr_pend_reg && idx_reg == fdsm_pkg::IDX_SYNC_CTL;

  // ahb-lite: writes without wait, reads with one wait state so the
  // data always reflects a write that completed just before
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg     <= '0;
      hreadyout   <= 1'b1;
      hresp       <= fdsm_pkg::HRESP_OKAY;
      hrdata      <= fdsm_pkg::RST_WORD;
    end else begin
      hresp       <= fdsm_pkg::HRESP_OKAY;
      wr_pend_reg <= take && hwrite;
      if (take) begin
        idx_reg <= word_index(haddr);
      end
      if (take && !hwrite) begin
        rd_pend_reg <= 1'b1;
        hreadyout   <= 1'b0;
      end else if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        hreadyout   <= 1'b1;
        hrdata      <= rd_word;
      end
    end
  end

  // read mux; unmapped indices and reserved bits read zero
  always_comb begin
    rd_word = fdsm_pkg::RST_WORD;
    unique case (idx_reg)
      fdsm_pkg::IDX_UP_LO:    rd_word[7:0]      = up_lo_reg;
      fdsm_pkg::IDX_UP_HI:    rd_word[HI_W-1:0] = up_hi_reg;
      fdsm_pkg::IDX_LO_LO:    rd_word[7:0]      = lo_lo_reg;
      fdsm_pkg::IDX_LO_HI:    rd_word[HI_W-1:0] = lo_hi_reg;
      fdsm_pkg::IDX_DW_LO:    rd_word[7:0]      = dw_lo_reg;
      fdsm_pkg::IDX_DW_HI:    rd_word[7:0]      = dw_hi_reg;
      fdsm_pkg::IDX_SYNC_CTL: rd_word[1:0]      = sync_ctl_reg;
      fdsm_pkg::IDX_MON_CTL:  rd_word[fdsm_pkg::PEAK_EN_BIT] = peak_detect_enable;
      fdsm_pkg::IDX_IRQ_STAT: rd_word[fdsm_pkg::IRQ_W-1:0] = irq_stat_reg;
      fdsm_pkg::IDX_IRQ_MASK: rd_word[fdsm_pkg::IRQ_W-1:0] = irq_mask_reg;
      default:                rd_word = fdsm_pkg::RST_WORD;
    endcase
  end

  // threshold and dwell registers; reserved high bits are simply not stored
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      up_lo_reg <= fdsm_pkg::RST_BYTE;
      up_hi_reg <= '0;
      lo_lo_reg <= fdsm_pkg::RST_BYTE;
      lo_hi_reg <= '0;
      dw_lo_reg <= fdsm_pkg::RST_BYTE;
      dw_hi_reg <= fdsm_pkg::RST_BYTE;
    end else if (wr_pend_reg) begin
      unique case (idx_reg)
        fdsm_pkg::IDX_UP_LO: up_lo_reg <= hwdata[7:0];
        fdsm_pkg::IDX_UP_HI: up_hi_reg <= hwdata[HI_W-1:0];
        fdsm_pkg::IDX_LO_LO: lo_lo_reg <= hwdata[7:0];
        fdsm_pkg::IDX_LO_HI: lo_hi_reg <= hwdata[HI_W-1:0];
        fdsm_pkg::IDX_DW_LO: dw_lo_reg <= hwdata[7:0];
        fdsm_pkg::IDX_DW_HI: dw_hi_reg <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // peak detector enable
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      peak_detect_enable <= 1'b0;
    end else if (wr_pend_reg && idx_reg == fdsm_pkg::IDX_MON_CTL) begin
      peak_detect_enable <= hwdata[fdsm_pkg::PEAK_EN_BIT];
    end
  end

  // fast detect
  assign up_thr    = {up_hi_reg, up_lo_reg};
  assign lo_thr    = {lo_hi_reg, lo_lo_reg};
  assign dwell_val = {dw_hi_reg, dw_lo_reg};
  assign above_up  = fine_magnitude > up_thr;
  assign below_lo  = fine_magnitude < lo_thr;

  // release on the dwell-th consecutive sample below; a dwell of zero acts as one
  always_comb begin
    alarm_next = threshold_alarm_output;
    if (above_up) begin
      alarm_next = 1'b1;
    end else if (threshold_alarm_output && below_lo && dwell_cnt_reg <= 1) begin
      alarm_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      threshold_alarm_output <= 1'b0;
      dwell_cnt_reg          <= '0;
    end else begin
      threshold_alarm_output <= alarm_next;
      if (above_up || !below_lo || !threshold_alarm_output) begin
        dwell_cnt_reg <= dwell_val;
      end else if (dwell_cnt_reg > 1) begin
        dwell_cnt_reg <= dwell_cnt_reg - 1'b1;
      end
    end
  end

  // sysref pin crossing; first stage feeds only the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sysref_meta_reg <= 1'b0;
      sysref_sync_reg <= 1'b0;
      sysref_prev_reg <= 1'b0;
    end else begin
      sysref_meta_reg <= sysref_pin;
      sysref_sync_reg <= sysref_meta_reg;
      sysref_prev_reg <= sysref_sync_reg;
    end
  end

  assign sysref_edge = sysref_sync_reg && !sysref_prev_reg;
  assign valid_edge  = sysref_edge && sync_ctl_reg[fdsm_pkg::SYNC_EN_BIT];

  // a software write in the capture cycle wins, so re-arming is never lost
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync_ctl_reg       <= fdsm_pkg::RST_SYNC;
      monitor_sync_pulse <= 1'b0;
    end else begin
      monitor_sync_pulse <= valid_edge;
      if (wr_sync) begin
        sync_ctl_reg <= hwdata[fdsm_pkg::SYNC_W-1:0];
      end else if (valid_edge && sync_ctl_reg[fdsm_pkg::SYNC_NEXT_BIT]) begin
        sync_ctl_reg[fdsm_pkg::SYNC_EN_BIT] <= 1'b0;
      end
    end
  end

  // interrupts: sticky, write one to clear, set wins over clear
  assign irq_set[fdsm_pkg::IRQ_ALARM_ON]  = alarm_next && !threshold_alarm_output;
  assign irq_set[fdsm_pkg::IRQ_ALARM_OFF] = !alarm_next && threshold_alarm_output;
  assign irq_set[fdsm_pkg::IRQ_SYNC]      = valid_edge;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_stat_reg <= fdsm_pkg::RST_IRQ;
      irq_mask_reg <= fdsm_pkg::RST_IRQ;
      irq          <= 1'b0;
    end else begin
      if (wr_pend_reg && idx_reg == fdsm_pkg::IDX_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~hwdata[fdsm_pkg::IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      if (wr_pend_reg && idx_reg == fdsm_pkg::IDX_IRQ_MASK) begin
        irq_mask_reg <= hwdata[fdsm_pkg::IRQ_W-1:0];
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // checks
  property p_upper_trip;
    @(posedge clock) disable iff (!resetn)
      fine_magnitude > up_thr |=> threshold_alarm_output;
  endproperty
  a_upper_trip: assert property (p_upper_trip) else $error("alarm missed upper crossing");

  property p_release_below;
    @(posedge clock) disable iff (!resetn)
      $fell(threshold_alarm_output) |-> $past(fine_magnitude) < $past(lo_thr);
  endproperty
  a_release_below: assert property (p_release_below) else $error("release not below lower");

  property p_dwell_hold;
    @(posedge clock) disable iff (!resetn)
      (threshold_alarm_output && below_lo && !above_up && dwell_cnt_reg > 1)
        |=> threshold_alarm_output && dwell_cnt_reg == $past(dwell_cnt_reg) - 1;
  endproperty
  a_dwell_hold: assert property (p_dwell_hold) else $error("alarm released before dwell");

  property p_reload;
    @(posedge clock) disable iff (!resetn)
      (threshold_alarm_output && !below_lo && !wr_pend_reg)
        |=> threshold_alarm_output && dwell_cnt_reg == $past(dwell_val);
  endproperty
  a_reload: assert property (p_reload) else $error("dwell counter not reloaded");

  property p_sync_off;
    @(posedge clock) disable iff (!resetn)
      !sync_ctl_reg[fdsm_pkg::SYNC_EN_BIT] |=> !monitor_sync_pulse;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync pulse while disabled");

  property p_continuous;
    @(posedge clock) disable iff (!resetn)
      (sysref_edge && sync_ctl_reg == 2'h1 && !wr_sync)
        |=> monitor_sync_pulse && sync_ctl_reg == 2'h1;
  endproperty
  a_continuous: assert property (p_continuous) else $error("continuous sync lost");

  property p_next_clear;
    @(posedge clock) disable iff (!resetn)
      (sysref_edge && sync_ctl_reg == 2'h3 && !wr_sync)
        |=> monitor_sync_pulse && sync_ctl_reg == 2'h2;
  endproperty
  a_next_clear: assert property (p_next_clear) else $error("next-edge enable not cleared");

  property p_peak;
    @(posedge clock) disable iff (!resetn)
      (wr_pend_reg && idx_reg == fdsm_pkg::IDX_MON_CTL)
        |=> peak_detect_enable == $past(hwdata[fdsm_pkg::PEAK_EN_BIT]);
  endproperty
  a_peak: assert property (p_peak) else $error("peak enable not written");

  property p_reserved_zero;
    @(posedge clock) disable iff (!resetn)
      (rd_pend_reg && (idx_reg == fdsm_pkg::IDX_UP_HI || idx_reg == fdsm_pkg::IDX_SYNC_CTL))
        |=> hrdata[31:HI_W] == '0 && hreadyout;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

  property p_trip_only;
    @(posedge clock) disable iff (!resetn)
      (!threshold_alarm_output && !above_up) |=> !threshold_alarm_output;
  endproperty
  a_trip_only: assert property (p_trip_only) else $error("stray alarm rise");

  property p_thr_hold;
    @(posedge clock) disable iff (!resetn)
      !wr_pend_reg |=> $stable(up_thr) && $stable(lo_thr) && $stable(dwell_val);
  endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("config moved");

  property p_peak_hold;
    @(posedge clock) disable iff (!resetn)
      !(wr_pend_reg && idx_reg == fdsm_pkg::IDX_MON_CTL) |=> $stable(peak_detect_enable);
  endproperty
  a_peak_hold: assert property (p_peak_hold) else $error("peak enable moved");

  property p_next_ignore;
    @(posedge clock) disable iff (!resetn)
      (sync_ctl_reg == 2'h2 && !wr_sync) |=> !monitor_sync_pulse && sync_ctl_reg == 2'h2;
  endproperty
  a_next_ignore: assert property (p_next_ignore) else $error("later edge not ignored");

  property p_one_pulse;
    @(posedge clock) disable iff (!resetn)
      monitor_sync_pulse |=> !monitor_sync_pulse;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("sync pulse too long");

endmodule
`default_nettype wire

// *** test/fdsm_gain_ctrl_model.sv ***
// gain control model watching the alarm pin, and the sysref source
`timescale 1ns/1ps
`default_nettype none
module fdsm_gain_ctrl_model #(
  parameter int MON_PERIOD  = 8,
  parameter int SYSREF_MULT = 2
) (
  input  wire logic   clock,
  input  wire logic   resetn,
  input  wire logic   threshold_alarm_output,
  input  wire logic   sysref_run,
  output logic        sysref_pin,
  output logic [15:0] alarm_rise_cnt
);
  int   phase;
  logic alarm_q;
  // period a whole multiple of the monitor period, else continuous resync drifts
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase <= 0;
      sysref_pin <= 1'b0;
    end else if (!sysref_run) begin
      phase <= 0;
      sysref_pin <= 1'b0;
    end else begin
      phase <= (phase == MON_PERIOD * SYSREF_MULT - 1) ? 0 : phase + 1;
      sysref_pin <= (phase < MON_PERIOD / 2);
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      alarm_q <= 1'b0;
      alarm_rise_cnt <= 16'h0000;
    end else begin
      alarm_q <= threshold_alarm_output;
      if (threshold_alarm_output && !alarm_q) begin
        alarm_rise_cnt <= alarm_rise_cnt + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/fdsm_ctrl_tb.sv ***
// self-checking bench for the fast detect and signal monitor control block
`timescale 1ns/1ps
`default_nettype none
module fdsm_ctrl_tb;
  localparam logic [11:0] REGS [8] = '{fdsm_pkg::IDX_UP_LO, fdsm_pkg::IDX_UP_HI,
    fdsm_pkg::IDX_LO_LO, fdsm_pkg::IDX_LO_HI, fdsm_pkg::IDX_DW_LO, fdsm_pkg::IDX_DW_HI,
    fdsm_pkg::IDX_SYNC_CTL, fdsm_pkg::IDX_MON_CTL};
  localparam logic [7:0]  WMASK [8] = '{8'hff, 8'h1f, 8'hff, 8'h1f, 8'hff, 8'hff, 8'h03, 8'h02};
  localparam logic [12:0] HAND [12] = '{13'h0064, 13'h0065, 13'h0014, 13'h0014, 13'h0028,
    13'h0014, 13'h0014, 13'h003c, 13'h0014, 13'h0014, 13'h0014, 13'h0000};
  logic        clock, resetn, hsel, hwrite, sysref_run, sysref_pin, chk_fd;
  logic        hreadyout, hresp, alarm, sync_pulse, peak_en, irq, a_m, rose, fell;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [12:0] mag, up_t, lo_t;
  logic [15:0] dw_t, c_m, rises, rise_cnt;
  int          error_cnt = 0, n_compared = 0, sp_cnt = 0;

  fdsm_ctrl fdsm_ctrl_i (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fine_magnitude(mag),
    .sysref_pin(sysref_pin), .threshold_alarm_output(alarm), .monitor_sync_pulse(sync_pulse),
    .peak_detect_enable(peak_en), .irq(irq));
  fdsm_gain_ctrl_model fdsm_gain_ctrl_model_i (.clock(clock), .resetn(resetn),
    .threshold_alarm_output(alarm), .sysref_run(sysref_run), .sysref_pin(sysref_pin),
    .alarm_rise_cnt(rise_cnt));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic report_and_stop;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // one single ahb-lite transfer; returns read data in rd
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    int k;
    hsel <= 1'b1;
    haddr <= {18'h0_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    k = 0;
    do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 64);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 64);
    rd = hrdata;
    if (k >= 64) begin
      $display("[ERR] hready exp 1 got %b", hreadyout);
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic rchk(input logic [11:0] idx, input logic [31:0] exp, input string nm);
    bus(1'b0, idx, 32'h0000_0000);
    chk(nm, exp, rd);
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask

  task automatic burst(input int exp);
    int s0;
    s0 = sp_cnt;
    sysref_run <= 1'b1; // sysref source enabled before sync is relied on
    repeat (48) @(posedge clock);
    sysref_run <= 1'b0;
    repeat (24) @(posedge clock);
    chk("sync pulses", exp, sp_cnt - s0);
  endtask

  // reference of the alarm with its dwell counter
  always @(posedge clock) begin
    if (!resetn) begin
      a_m <= 1'b0; c_m <= 16'h0000; rises <= 16'h0000; rose <= 1'b0; fell <= 1'b0;
    end else if (mag > up_t) begin
      a_m <= 1'b1;
      c_m <= 16'h0000;
      if (!a_m) begin rises <= rises + 16'h0001; rose <= 1'b1; end
    end else if (a_m && mag < lo_t) begin
      if (c_m + 16'h0001 >= ((dw_t == 16'h0000) ? 16'h0001 : dw_t)) begin
        a_m <= 1'b0; c_m <= 16'h0000; fell <= 1'b1;
      end else c_m <= c_m + 16'h0001;
    end else c_m <= 16'h0000;
    if (sync_pulse === 1'b1) sp_cnt++;
  end
  always @(negedge clock) if (chk_fd) chk("alarm", {31'h0000_0000, a_m}, {31'h0000_0000, alarm});

  initial begin
    #800000;
    $display("[ERR] watchdog exp done got hang");
    error_cnt++;
    report_and_stop();
  end

  initial begin
    void'($urandom(77518));
    {resetn, hsel, hwrite, sysref_run, chk_fd} = 5'h00;
    {htrans, hsize, haddr, hwdata} = '0;
    {mag, up_t, lo_t, dw_t} = '0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 8; i++) rchk(REGS[i], 32'h0000_0000, "reset value");
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, REGS[i], 32'hffff_ffff);
      rchk(REGS[i], {24'h00_0000, WMASK[i]}, "rw mask");
    end
    chk("peak on", 32'h0000_0001, {31'h0000_0000, peak_en});
    bus(1'b1, fdsm_pkg::IDX_MON_CTL, 32'h0000_0000);
    @(posedge clock);
    chk("peak off", 32'h0000_0000, {31'h0000_0000, peak_en});
    bus(1'b1, 12'h250, 32'hffff_ffff);
    rchk(12'h250, 32'h0000_0000, "unmapped");
    bus(1'b1, fdsm_pkg::IDX_SYNC_CTL, 32'h0000_0000);
    for (int r = 0; r < 5; r++) begin
      if (r == 0) {up_t, lo_t, dw_t} = {13'h0064, 13'h0028, 16'h0003};
      else begin
        up_t = 13'($urandom_range(8000, 1000));
        lo_t = 13'($urandom_range(up_t - 1, 1));
        dw_t = 16'($urandom_range(6, 0));
      end
      // reserved high bits written with garbage must not disturb the thresholds
      bus(1'b1, fdsm_pkg::IDX_UP_LO, {24'h00_0000, up_t[7:0]});
      bus(1'b1, fdsm_pkg::IDX_UP_HI, ($urandom() & 32'hffff_ffe0) | up_t[12:8]);
      bus(1'b1, fdsm_pkg::IDX_LO_LO, {24'h00_0000, lo_t[7:0]});
      bus(1'b1, fdsm_pkg::IDX_LO_HI, ($urandom() & 32'hffff_ffe0) | lo_t[12:8]);
      bus(1'b1, fdsm_pkg::IDX_DW_LO, {24'h00_0000, dw_t[7:0]});
      bus(1'b1, fdsm_pkg::IDX_DW_HI, {24'h00_0000, dw_t[15:8]});
      chk_fd <= 1'b1;
      if (r == 0) foreach (HAND[j]) begin @(posedge clock); mag <= HAND[j]; end
      else repeat (300) begin
        @(posedge clock);
        case ($urandom_range(3, 0))
          0: mag <= 13'($urandom_range(8191, up_t + 1));
          1: mag <= 13'($urandom_range(up_t, lo_t));
          default: mag <= 13'($urandom_range(lo_t - 1, 0));
        endcase
      end
      @(posedge clock);
      mag <= 13'h0000;
      repeat (12) @(posedge clock);
      chk_fd <= 1'b0;
    end
    chk("alarm rises", {16'h0000, rises}, {16'h0000, rise_cnt});
    burst(0);
    rchk(fdsm_pkg::IDX_SYNC_CTL, 32'h0000_0000, "sync off");
    bus(1'b1, fdsm_pkg::IDX_SYNC_CTL, 32'h0000_0001);
    burst(3);
    rchk(fdsm_pkg::IDX_SYNC_CTL, 32'h0000_0001, "sync cont");
    bus(1'b1, fdsm_pkg::IDX_SYNC_CTL, 32'h0000_0003);
    burst(1);
    rchk(fdsm_pkg::IDX_SYNC_CTL, 32'h0000_0002, "sync next");
    chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
    bus(1'b1, fdsm_pkg::IDX_IRQ_MASK, 32'h0000_0007);
    repeat (3) @(posedge clock);
    chk("irq on", 32'h0000_0001, {31'h0000_0000, irq});
    rchk(fdsm_pkg::IDX_IRQ_STAT, {29'h0000_0000, 1'b1, fell, rose}, "irq status");
    bus(1'b1, fdsm_pkg::IDX_IRQ_STAT, 32'h0000_0007);
    repeat (3) @(posedge clock);
    chk("irq clr", 32'h0000_0000, {31'h0000_0000, irq});
    rchk(fdsm_pkg::IDX_IRQ_STAT, 32'h0000_0000, "status clr");
    report_and_stop();
  end
endmodule
`default_nettype wire
